// >>> dcce_regs.svh
`ifndef DCCE_REGS_SVH
`define DCCE_REGS_SVH
`define DCCE_NCHAN      4
`define DCCE_CTRL_OFS   4'h0
`define DCCE_EVCT_OFS   4'h4
`define DCCE_MAP_TOP    2'h0
`define DCCE_BUSY_BIT   15
`define DCCE_CHNS_BIT   8
`define DCCE_ON_BIT     7
`define DCCE_AED_BIT    6
`define DCCE_CHN_BIT    5
`define DCCE_AEN_BIT    4
`define DCCE_EDET_BIT   2
`define DCCE_PRI_LSB    0
`define DCCE_AIRQ_LSB   16
`define DCCE_SIRQ_LSB   8
`define DCCE_FORCE_BIT  7
`define DCCE_SWAB_BIT   6
`define DCCE_PATTERN_ABORT_ENABLE_BIT  5
`define DCCE_START_IRQ_ENABLE_BIT 4
`define DCCE_ABORT_IRQ_ENABLE_BIT 3
`define DCCE_IRQ_RST    8'hFF
`endif

// >>> dcce_pkg.sv
`include "dcce_regs.svh"
package dcce_pkg;
   typedef enum logic [0:0] {
      DCCE_IDLE = 1'b0,
      DCCE_RUN  = 1'b1
   } dcce_phase_e;
   typedef struct packed {
      logic       on;
      logic       aed;
      logic       chain;
      logic       aen;
      logic       chns;
      logic       edet;
      logic       pattern_abort_enable;
      logic       sen;
      logic       aen_irq;
      logic [1:0] pri;
      logic [7:0] airq;
      logic [7:0] sirq;
      logic       pend;
   } dcce_chan_s;
   typedef struct packed {
      dcce_chan_s [`DCCE_NCHAN-1:0] ch;
      dcce_phase_e                  phase;
      logic [1:0]                   cur;
      logic                         ack;
      logic [31:0]                  rdat;
      logic                         go;
      logic                         stop;
      logic [`DCCE_NCHAN-1:0]       taf;
   } dcce_state_s;
   typedef struct packed {
      logic done;
      logic block;
      logic pattern;
   } dcce_mover_in_s;
   typedef struct packed {
      logic       start;
      logic       abort;
      logic [1:0] chan;
   } dcce_mover_out_s;
endpackage

// >>> dcce_top.sv
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "dcce_regs.svh"
// How it works
// - Busy reads 1 while channel transfers.
// - Chain direction picks enabling neighbour channel.
// - Chain direction only matters with chaining.
// - Enable bit turns channel on; clear suspends.
// - Suspend waits for current cell; poll busy.
// - Option records events while channel off.
// - Chain enable permits neighbour to enable.
// - Without auto enable, block done disables.
// - Event seen bit set on start event.
// - Priority field: 3 highest, 0 lowest.
// - Unimplemented control bits read zero.
// - Abort number selects aborting interrupt, flags.
// - Start number selects starting interrupt.
// - Force write starts; reads zero.
// - Software abort write aborts; reads zero.
// - Pattern match aborts, clears enable if on.
// - Start enable gates start interrupt.
// - Abort enable gates abort interrupt.
// - Abort interrupt ignored when not enabled.
// - Interrupt abort raises transfer abort flag.
module dcce_top
   import dcce_pkg::*;
(
   input  wire logic             clk_i,     // Clock.
   input  wire logic             rst_i,     // Sync reset.
   input  wire logic             wb_cyc_i,  // Bus cycle.
   input  wire logic             wb_stb_i,  // Bus strobe.
   input  wire logic             wb_we_i,   // Write.
   input  wire logic [7:0]       wb_adr_i,  // Byte address.
   input  wire logic [3:0]       wb_sel_i,  // Byte lanes.
   input  wire logic [31:0]      wb_dat_i,  // Write data.
   output      logic [31:0]      wb_dat_o,  // Read data.
   output      logic             wb_ack_o,  // Ack.
   input  wire logic [255:0]     irq_i,     // Interrupt sources.
   input  wire dcce_mover_in_s   mover_i,   // Mover status.
   output      dcce_mover_out_s  mover_o,   // Mover command.
   output      logic [3:0]       taf_o      // Abort flag pulses.
);

   dcce_state_s st_reg;
   dcce_state_s st_next;
   logic        wr;
   logic        mapped;
   logic [3:0]  blkv;
   logic [3:0]  ev;
   logic [2:0]  pk;
   logic [31:0] m;
   logic        sev;
   logic        aev;
   logic        own;
   logic        allow;

   function automatic logic [31:0] rd_reg(input dcce_state_s s, input logic [1:0] k, input logic [3:0] ofs);
      dcce_chan_s  c;
      logic [31:0] v;
      c = s.ch[k];
      v = 32'h0000_0000;
      if (ofs == `DCCE_CTRL_OFS) begin
         v[`DCCE_BUSY_BIT] = (s.phase == DCCE_RUN) && (s.cur == k);
         v[`DCCE_CHNS_BIT] = c.chns;
         v[`DCCE_ON_BIT] = c.on;
         v[`DCCE_AED_BIT] = c.aed;
         v[`DCCE_CHN_BIT] = c.chain;
         v[`DCCE_AEN_BIT] = c.aen;
         v[`DCCE_EDET_BIT] = c.edet;
         v[`DCCE_PRI_LSB +: 2] = c.pri;
      end else if (ofs == `DCCE_EVCT_OFS) begin
         v[`DCCE_AIRQ_LSB +: 8] = c.airq;
         v[`DCCE_SIRQ_LSB +: 8] = c.sirq;
         v[`DCCE_PATTERN_ABORT_ENABLE_BIT] = c.pattern_abort_enable;
         v[`DCCE_START_IRQ_ENABLE_BIT] = c.sen;
         v[`DCCE_ABORT_IRQ_ENABLE_BIT] = c.aen_irq;
      end
      return v;
   endfunction

   function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] v;
      v = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            v[8*b +: 8] = d[8*b +: 8];
         end
      end
      return v;
   endfunction

   // Ties go to the lowest index because the scan runs downward with >=.
   function automatic logic [2:0] pick(input dcce_state_s s);
      logic [2:0] p;
      logic [1:0] best;
      p = 3'h0;
      best = 2'h0;
      for (int k = `DCCE_NCHAN - 1; k >= 0; k--) begin
         if (s.ch[k].pend && s.ch[k].on && (!p[2] || s.ch[k].pri >= best)) begin
            p = {1'b1, 2'(k)};
            best = s.ch[k].pri;
         end
      end
      return p;
   endfunction

   always_comb begin
      st_next = st_reg;
      st_next.go = 1'b0;
      st_next.stop = 1'b0;
      st_next.taf = 4'h0;
      st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
      st_next.rdat = 32'h0000_0000;
      wr = st_next.ack && wb_we_i;
      mapped = wb_adr_i[7:6] == `DCCE_MAP_TOP;
      m = 32'h0000_0000;
      sev = 1'b0;
      aev = 1'b0;
      own = 1'b0;
      allow = 1'b0;
      ev = 4'h0;
      pk = 3'h0;
      if (st_next.ack && !wb_we_i && mapped) begin
         st_next.rdat = rd_reg(st_reg, wb_adr_i[5:4], wb_adr_i[3:0]);
      end
      blkv = 4'h0;
      if (st_reg.phase == DCCE_RUN && mover_i.done && mover_i.block) begin
         blkv[st_reg.cur] = 1'b1;
      end
      for (int c = 0; c < `DCCE_NCHAN; c++) begin
         own = (st_reg.phase == DCCE_RUN) && (st_reg.cur == 2'(c));
         allow = st_reg.ch[c].on || st_reg.ch[c].aed;
         sev = 1'b0;
         aev = 1'b0;
         if (wr && mapped && wb_adr_i[5:4] == 2'(c) && wb_adr_i[3:0] == `DCCE_CTRL_OFS) begin
            m = wmask(rd_reg(st_reg, 2'(c), `DCCE_CTRL_OFS), wb_dat_i, wb_sel_i);
            st_next.ch[c].chns = m[`DCCE_CHNS_BIT];
            st_next.ch[c].on = m[`DCCE_ON_BIT];
            st_next.ch[c].aed = m[`DCCE_AED_BIT];
            st_next.ch[c].chain = m[`DCCE_CHN_BIT];
            st_next.ch[c].aen = m[`DCCE_AEN_BIT];
            st_next.ch[c].pri = m[`DCCE_PRI_LSB +: 2];
         end
         if (wr && mapped && wb_adr_i[5:4] == 2'(c) && wb_adr_i[3:0] == `DCCE_EVCT_OFS) begin
            m = wmask(rd_reg(st_reg, 2'(c), `DCCE_EVCT_OFS), wb_dat_i, wb_sel_i);
            st_next.ch[c].airq = m[`DCCE_AIRQ_LSB +: 8];
            st_next.ch[c].sirq = m[`DCCE_SIRQ_LSB +: 8];
            st_next.ch[c].pattern_abort_enable = m[`DCCE_PATTERN_ABORT_ENABLE_BIT];
            st_next.ch[c].sen = m[`DCCE_START_IRQ_ENABLE_BIT];
            st_next.ch[c].aen_irq = m[`DCCE_ABORT_IRQ_ENABLE_BIT];
            sev = wb_sel_i[0] && wb_dat_i[`DCCE_FORCE_BIT];
            aev = wb_sel_i[0] && wb_dat_i[`DCCE_SWAB_BIT];
         end
         // Chaining turns the channel on; it still needs a start event to move data.
         if (st_reg.ch[c].chain) begin
            if (st_reg.ch[c].chns) begin
               if (c < `DCCE_NCHAN - 1 && blkv[(c + 1) % `DCCE_NCHAN]) begin
                  st_next.ch[c].on = 1'b1;
               end
            end else if (c > 0 && blkv[(c + `DCCE_NCHAN - 1) % `DCCE_NCHAN]) begin
               st_next.ch[c].on = 1'b1;
            end
         end
         // A cleared enable lets the running cell finish; busy drops here at done, or earlier on a pattern or abort stop below.
         if (own && mover_i.done) begin
            st_next.phase = DCCE_IDLE;
            if (mover_i.block && !st_reg.ch[c].aen) begin
               st_next.ch[c].on = 1'b0;
            end
         end
         if (own && mover_i.pattern && st_reg.ch[c].pattern_abort_enable) begin
            st_next.stop = 1'b1;
            st_next.phase = DCCE_IDLE;
            st_next.ch[c].on = 1'b0;
         end
         if (irq_i[st_reg.ch[c].airq] && st_reg.ch[c].aen_irq && allow) begin
            st_next.taf[c] = 1'b1;
            aev = 1'b1;
         end
         if (aev && allow) begin
            st_next.ch[c].pend = 1'b0;
            if (own) begin
               st_next.stop = 1'b1;
               st_next.phase = DCCE_IDLE;
            end
         end
         if (irq_i[st_reg.ch[c].sirq] && st_reg.ch[c].sen) begin
            sev = 1'b1;
         end
         if (sev && allow) begin
            st_next.ch[c].pend = 1'b1;
            st_next.ch[c].edet = 1'b1;
            ev[c] = 1'b1;
         end
      end
      unique case (st_reg.phase)
         DCCE_IDLE: begin
            pk = pick(st_reg);
            if (pk[2] && st_next.ch[pk[1:0]].pend && st_next.ch[pk[1:0]].on) begin
               st_next.go = 1'b1;
               st_next.cur = pk[1:0];
               st_next.phase = DCCE_RUN;
               st_next.ch[pk[1:0]].pend = 1'b0;
               if (!ev[pk[1:0]]) begin
                  st_next.ch[pk[1:0]].edet = 1'b0;
               end
            end
         end
         DCCE_RUN: begin
            pk = 3'h0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         for (int c = 0; c < `DCCE_NCHAN; c++) begin
            st_reg.ch[c].airq <= `DCCE_IRQ_RST;
            st_reg.ch[c].sirq <= `DCCE_IRQ_RST;
         end
      end else begin
         st_reg <= st_next;
      end
   end

   assign wb_dat_o = st_reg.rdat;
   assign wb_ack_o = st_reg.ack;
   assign mover_o = '{start: st_reg.go, abort: st_reg.stop, chan: st_reg.cur};
   assign taf_o = st_reg.taf;

   logic wr0;
   logic wr1;
   logic req_rd;
   assign wr0 = wr && mapped && wb_adr_i[5:4] == 2'h0;
   assign wr1 = wr && mapped && wb_adr_i[5:4] == 2'h1;
   assign req_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_own0;
      st_reg.phase == DCCE_RUN && st_reg.cur == 2'h0;
   endsequence
   sequence s_blk0;
      s_own0 ##0 (mover_i.done && mover_i.block && !wr0);
   endsequence
   sequence s_rd_ctrl;
      (req_rd && wb_adr_i == 8'h00) ##1 wb_ack_o;
   endsequence
   sequence s_rd_evct;
      (req_rd && wb_adr_i == 8'h04) ##1 wb_ack_o;
   endsequence

   // Register writes to channel 0, split by word, for the field checks below.
   sequence s_wr0_ctrl;
      wr0 && wb_adr_i[3:0] == `DCCE_CTRL_OFS;
   endsequence
   sequence s_wr0_evct;
      wr0 && wb_adr_i[3:0] == `DCCE_EVCT_OFS;
   endsequence

   logic abt0;
   assign abt0 = irq_i[st_reg.ch[0].airq] && st_reg.ch[0].aen_irq;

   chk_busy_hold: assert property (s_own0 ##0 (!mover_i.done && !mover_i.pattern
      && !irq_i[st_reg.ch[0].airq] && !wr0) |=> s_own0)
      else $error("busy dropped early");
   chk_auto_off: assert property (s_blk0 ##0 !st_reg.ch[0].aen |=> !st_reg.ch[0].on)
      else $error("block done left channel on");
   chk_auto_keep: assert property (s_blk0 ##0 (st_reg.ch[0].aen && st_reg.ch[0].on && !mover_i.pattern)
      |=> st_reg.ch[0].on) else $error("auto enable lost");
   chk_pat_abort: assert property (s_own0 ##0 (mover_i.pattern && st_reg.ch[0].pattern_abort_enable && !wr0)
      |=> !st_reg.ch[0].on && mover_o.abort) else $error("pattern abort missing");
   chk_start_rec: assert property ((irq_i[st_reg.ch[0].sirq] && st_reg.ch[0].sen && st_reg.ch[0].on
      && st_reg.phase == DCCE_RUN) |=> st_reg.ch[0].pend && st_reg.ch[0].edet)
      else $error("start event not recorded");
   chk_off_ignore: assert property ((!st_reg.ch[0].on && !st_reg.ch[0].aed && !st_reg.ch[0].pend && !wr0)
      |=> !st_reg.ch[0].pend) else $error("event taken while off");
   chk_abort_flag: assert property ((irq_i[st_reg.ch[0].airq] && st_reg.ch[0].aen_irq
      && st_reg.ch[0].on) |=> taf_o[0]) else $error("abort flag missing");
   chk_abort_mask: assert property (!st_reg.ch[0].aen_irq |=> !taf_o[0])
      else $error("masked abort flagged");
   chk_ctrl_zero: assert property (s_rd_ctrl |-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[14:9] == 6'h00
      && !wb_dat_o[3]) else $error("control reserved bits set");
   chk_evct_zero: assert property (s_rd_evct |-> wb_dat_o[7:6] == 2'h0 && wb_dat_o[31:24] == 8'h00)
      else $error("strobe bits read set");
   chk_chain_off: assert property ((!st_reg.ch[1].chain && !st_reg.ch[1].on && !wr1)
      |=> !st_reg.ch[1].on) else $error("chained while disallowed");
   chk_chain_on: assert property (s_blk0 ##0 (st_reg.ch[1].chain && !st_reg.ch[1].chns && !wr1)
      |=> st_reg.ch[1].on) else $error("chain enable missing");
   chk_off_nogrant: assert property ((st_reg.phase == DCCE_IDLE && !st_reg.ch[0].on && !wr0)
      |=> !(mover_o.start && mover_o.chan == 2'h0)) else $error("granted while off");

   // Field stores: the written byte lanes land in the register one edge later.
   chk_pri_store: assert property (s_wr0_ctrl ##0 wb_sel_i[0]
      |=> st_reg.ch[0].pri == $past(wb_dat_i[1:0])) else $error("priority not stored");
   chk_sirq_store: assert property (s_wr0_evct ##0 wb_sel_i[1]
      |=> st_reg.ch[0].sirq == $past(wb_dat_i[15:8])) else $error("start number not stored");
   chk_airq_store: assert property (s_wr0_evct ##0 wb_sel_i[2]
      |=> st_reg.ch[0].airq == $past(wb_dat_i[23:16])) else $error("abort number not stored");

   // Software strobes act at the commit edge and leave nothing stored behind.
   chk_force_take: assert property (s_wr0_evct ##0 (wb_sel_i[0] && wb_dat_i[`DCCE_FORCE_BIT]
      && st_reg.ch[0].on) |=> st_reg.ch[0].pend || (st_reg.phase == DCCE_RUN && st_reg.cur == 2'h0))
      else $error("forced start lost");
   chk_swab_stop: assert property (s_own0 ##0 s_wr0_evct ##0 (wb_sel_i[0]
      && wb_dat_i[`DCCE_SWAB_BIT] && st_reg.ch[0].on) |=> mover_o.abort && st_reg.phase == DCCE_IDLE)
      else $error("software abort ignored");
   chk_taf_cause: assert property (taf_o[0] |-> $past(abt0))
      else $error("abort flag without enabled interrupt");

   // Arbitration between two ready channels.
   chk_prio_high: assert property ((st_reg.phase == DCCE_IDLE && st_reg.ch[0].pend && st_reg.ch[0].on
      && st_reg.ch[2].pend && st_reg.ch[2].on && st_reg.ch[2].pri > st_reg.ch[0].pri)
      |=> !(mover_o.start && mover_o.chan == 2'h0)) else $error("lower priority granted");
   chk_prio_tie: assert property ((st_reg.phase == DCCE_IDLE && st_reg.ch[0].pend && st_reg.ch[0].on
      && st_reg.ch[1].pend && st_reg.ch[1].on && st_reg.ch[1].pri == st_reg.ch[0].pri)
      |=> !(mover_o.start && mover_o.chan == 2'h1)) else $error("tie not given to lower index");

   // Busy as software reads it.
   chk_busy_read: assert property (s_own0 ##0 (req_rd && wb_adr_i == 8'h00)
      |=> wb_dat_o[`DCCE_BUSY_BIT]) else $error("busy reads zero while running");
   chk_idle_read: assert property ((req_rd && wb_adr_i == 8'h00 && st_reg.phase == DCCE_IDLE)
      |=> !wb_dat_o[`DCCE_BUSY_BIT]) else $error("busy reads one while idle");

   // Event gating and recording.
   chk_start_mask: assert property ((!st_reg.ch[0].sen && !st_reg.ch[0].pend && !wr0)
      |=> !st_reg.ch[0].pend) else $error("masked start recorded");
   chk_edet_off: assert property ((irq_i[st_reg.ch[0].sirq] && st_reg.ch[0].sen && st_reg.ch[0].aed
      && !st_reg.ch[0].on) |=> st_reg.ch[0].edet) else $error("event while off not seen");

   // Chain direction: only the selected neighbour's block completion enables.
   chk_chain_dn: assert property (s_blk0 ##0 (st_reg.ch[1].chain && st_reg.ch[1].chns
      && !st_reg.ch[1].on && !wr1) |=> !st_reg.ch[1].on) else $error("wrong neighbour enabled");
   chk_chain_up: assert property ((st_reg.phase == DCCE_RUN && st_reg.cur == 2'h2 && mover_i.done
      && mover_i.block && st_reg.ch[1].chain && st_reg.ch[1].chns && !wr1) |=> st_reg.ch[1].on)
      else $error("lower neighbour did not enable");
   chk_start_one: assert property (mover_o.start |=> !mover_o.start)
      else $error("start held longer than one cycle");

endmodule // dcce_top

// >>> dcce_mover_model.sv
`timescale 1ns/1ns
module dcce_mover_model
   import dcce_pkg::*;
#(
   parameter int DLY = 16
)(
   input  wire logic            clk_i, // Clock.
   input  wire logic            rst_i, // Sync reset.
   input  wire dcce_mover_out_s cmd_i, // Command from the block.
   input  wire logic            pat_i, // Pattern match request.
   output      dcce_mover_in_s  st_o   // Status to the block.
);
   logic [7:0] cnt_reg;
   logic       run_reg;
   // A cell runs DLY cycles; done only comes once the cell has finished.
   always_ff @(posedge clk_i) begin
      st_o <= '0;
      if (rst_i) begin
         run_reg <= 1'b0;
         cnt_reg <= 8'h00;
      end else if (cmd_i.abort) begin
         run_reg <= 1'b0;
      end else if (cmd_i.start) begin
         run_reg <= 1'b1;
         cnt_reg <= 8'(DLY);
      end else if (run_reg) begin
         cnt_reg <= cnt_reg - 8'h01;
         st_o.pattern <= pat_i;
         if (cnt_reg == 8'h01) begin
            run_reg <= 1'b0;
            st_o.done <= 1'b1;
            st_o.block <= 1'b1;
         end
      end
   end
endmodule // dcce_mover_model

// >>> testbench.sv
`timescale 1ns/1ns
module testbench
   import dcce_pkg::*;
;
   logic            clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pat = 1'b0;
   logic [7:0]      adr = 8'h00;
   logic [3:0]      sel = 4'h0;
   logic [31:0]     wdat = 32'h0000_0000, rd;
   logic [255:0]    irq = '0;
   logic [31:0]     wb_dat_o;
   logic            wb_ack_o;
   logic [3:0]      taf_o;
   dcce_mover_in_s  mv_i;
   dcce_mover_out_s mv_o;
   int              err_count = 0, checks = 0, st_n = 0, ab_n = 0, taf_n = 0, cyc_n = 0, s, a, t;
   logic [1:0]      grants[$];
   always #2 clk_i = ~clk_i;
   dcce_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .irq_i(irq), .mover_i(mv_i), .mover_o(mv_o), .taf_o(taf_o));
   dcce_mover_model #(.DLY(16)) mover_u (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(mv_o), .pat_i(pat),
      .st_o(mv_i));
   task automatic wrap_up();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n++;
      if (mv_o.start === 1'b1) begin
         st_n++;
         grants.push_back(mv_o.chan);
      end
      if (mv_o.abort === 1'b1) ab_n++;
      if (taf_o[1] === 1'b1) taf_n++;
      if (cyc_n == 5000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Classic cycle: hold everything until ack is sampled, then idle one cycle.
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      sel <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      tick(1);
      if (n >= 20) cmp(32'h0000_0001, 32'h0000_0000);
   endtask
   task automatic wr(input logic [1:0] c, input logic [3:0] o, input logic [31:0] d);
      bus(1'b1, {2'b00, c, o}, d);
   endtask
   task automatic chk(input logic [1:0] c, input logic [3:0] o, input logic [31:0] e);
      bus(1'b0, {2'b00, c, o}, 32'h0000_0000);
      cmp(rd, e);
   endtask
   task automatic fire(input int n);
      irq[n] <= 1'b1;
      tick(1);
      irq[n] <= 1'b0;
   endtask
   task automatic t_regs();
      for (int c = 0; c < 4; c++) begin
         chk(2'(c), 4'h0, 32'h0000_0000);
         chk(2'(c), 4'h4, 32'h00FF_FF00);
      end
      bus(1'b0, 8'hC0, 32'h0000_0000);
      cmp(rd, 32'h0000_0000);
      wr(2'd3, 4'h0, 32'hFFFF_FFFF);
      chk(2'd3, 4'h0, 32'h0000_01F3);
      wr(2'd3, 4'h0, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_start();
      s = st_n;
      wr(2'd0, 4'h4, 32'h00FF_0510);
      wr(2'd0, 4'h0, 32'h0000_0081);
      fire(5);
      // The grant lands one edge after the event is recorded, so wait for it before reading busy.
      tick(1);
      chk(2'd0, 4'h0, 32'h0000_8081);
      cmp(st_n, s + 1);
      tick(24);
      chk(2'd0, 4'h0, 32'h0000_0001);
      wr(2'd0, 4'h4, 32'h00FF_0500);
      wr(2'd0, 4'h0, 32'h0000_0080);
      fire(5);
      tick(24);
      cmp(st_n, s + 1);
      wr(2'd0, 4'h4, 32'h00FF_0510);
      wr(2'd0, 4'h0, 32'h0000_0040);
      fire(5);
      chk(2'd0, 4'h0, 32'h0000_0044);
      wr(2'd0, 4'h0, 32'h0000_00C0);
      tick(24);
      cmp(st_n, s + 2);
      chk(2'd0, 4'h0, 32'h0000_0040);
      wr(2'd0, 4'h0, 32'h0000_0000);
      fire(5);
      chk(2'd0, 4'h0, 32'h0000_0000);
      wr(2'd0, 4'h0, 32'h0000_0080);
      tick(24);
      cmp(st_n, s + 2);
      wr(2'd0, 4'h0, 32'h0000_0000);
      $display("test start done");
   endtask
   task automatic t_abort();
      a = ab_n;
      t = taf_n;
      wr(2'd1, 4'h4, 32'h0009_0618);
      wr(2'd1, 4'h0, 32'h0000_0090);
      fire(6);
      tick(4);
      fire(9);
      tick(3);
      cmp(ab_n, a + 1);
      cmp(taf_n, t + 1);
      chk(2'd1, 4'h0, 32'h0000_0090);
      wr(2'd1, 4'h4, 32'h0009_0610);
      fire(6);
      tick(4);
      fire(9);
      tick(24);
      cmp(ab_n, a + 1);
      cmp(taf_n, t + 1);
      fire(6);
      tick(4);
      wr(2'd1, 4'h4, 32'h0009_0650);
      tick(2);
      cmp(ab_n, a + 2);
      cmp(taf_n, t + 1);
      chk(2'd1, 4'h4, 32'h0009_0610);
      s = st_n;
      wr(2'd1, 4'h4, 32'h0009_0690);
      tick(2);
      cmp(st_n, s + 1);
      chk(2'd1, 4'h4, 32'h0009_0610);
      tick(24);
      wr(2'd1, 4'h0, 32'h0000_0000);
      $display("test abort done");
   endtask
   task automatic t_prio();
      grants.delete();
      wr(2'd0, 4'h4, 32'h00FF_0710);
      wr(2'd2, 4'h4, 32'h00FF_0710);
      wr(2'd0, 4'h0, 32'h0000_0081);
      wr(2'd2, 4'h0, 32'h0000_0083);
      fire(7);
      tick(50);
      cmp(grants.size(), 2);
      cmp(grants[0], 2);
      cmp(grants[1], 0);
      $display("test priority done");
   endtask
   task automatic t_chain();
      wr(2'd1, 4'h0, 32'h0000_0020);
      wr(2'd2, 4'h0, 32'h0000_0120);
      wr(2'd0, 4'h0, 32'h0000_0080);
      wr(2'd0, 4'h4, 32'h00FF_FF80);
      tick(24);
      chk(2'd1, 4'h0, 32'h0000_00A0);
      chk(2'd2, 4'h0, 32'h0000_0120);
      wr(2'd1, 4'h0, 32'h0000_0000);
      wr(2'd2, 4'h0, 32'h0000_0000);
      $display("test chain done");
   endtask
   task automatic t_pat();
      a = ab_n;
      for (int p = 1; p >= 0; p--) begin
         wr(2'd0, 4'h0, 32'h0000_0090);
         wr(2'd0, 4'h4, p ? 32'h00FF_FFA0 : 32'h00FF_FF80);
         tick(2);
         pat <= 1'b1;
         tick(1);
         pat <= 1'b0;
         tick(3);
         cmp(ab_n, a + 1);
         chk(2'd0, 4'h0, p ? 32'h0000_0010 : 32'h0000_8090);
         tick(24);
      end
      wr(2'd0, 4'h4, 32'h00FF_FF80);
      tick(2);
      wr(2'd0, 4'h0, 32'h0000_0010);
      chk(2'd0, 4'h0, 32'h0000_8010);
      tick(24);
      chk(2'd0, 4'h0, 32'h0000_0010);
      s = st_n;
      wr(2'd0, 4'h4, 32'h00FF_FF80);
      tick(4);
      cmp(st_n, s);
      $display("test pattern and suspend done");
   endtask
   initial begin
      tick(10);
      rst_i <= 1'b0;
      tick(1);
      t_regs();
      t_start();
      t_abort();
      t_prio();
      t_chain();
      t_pat();
      wrap_up();
   end
endmodule // testbench
